// file: common/bft_pkg.sv
// Constants and types for the breaker failure timer block.
// Assumes a 32-bit AXI4-Lite register bus and a program-cycle tick input.
package bft_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RET_DLY = 8'h04;
    localparam logic [7:0] OFF_CBF_DLY = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_CNT_CLR = 8'h10;
    localparam logic [7:0] OFF_CNT0 = 8'h14;
    localparam logic [7:0] OFF_CNT1 = 8'h18;
    localparam logic [7:0] OFF_CNT2 = 8'h1C;
    localparam logic [7:0] OFF_CNT3 = 8'h20;
    localparam logic [7:0] OFF_REC_SEL = 8'h24;
    localparam logic [7:0] OFF_REC_TIME = 8'h28;
    localparam logic [7:0] OFF_REC_CUR = 8'h2C;
    localparam logic [7:0] OFF_REC_REM = 8'h30;
    localparam logic [7:0] OFF_REC_EVT = 8'h34;
    // ----------------------------------------
    // Fields, resets and timing
    // ----------------------------------------
    localparam int CTRL_RET_EN_BIT = 2;
    localparam int CTRL_ON_LSB = 8;
    localparam int CTRL_OFF_LSB = 16;
    localparam logic [1:0] CRIT_CUR = 2'h0;
    localparam logic [1:0] CRIT_AND = 2'h1;
    localparam logic [1:0] CRIT_OR = 2'h2;
    localparam logic [1:0] CRIT_DIG = 2'h3;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam int STEP_MS = 5;
    localparam int RET_DELAY_MS = 100;
    localparam int CBF_DELAY_MS = 200;
    localparam int RET_TICKS = RET_DELAY_MS / STEP_MS;
    localparam int CBF_TICKS = CBF_DELAY_MS / STEP_MS;
    localparam int REC_DEPTH = 12;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_NORMAL = 5'h01,
        ST_START = 5'h02,
        ST_RETRIP = 5'h04,
        ST_CBF = 5'h08,
        ST_BLOCKED = 5'h10
    } bft_status_type;
    typedef struct packed {
        logic [31:0] stamp;
        logic [3:0] code;
        logic [15:0] ph;
        logic [15:0] res;
        logic [15:0] t_ret;
        logic [15:0] t_cbf;
        logic [2:0] grp;
    } bft_rec_type;
endpackage

// file: logic/bft_timer.sv
// Breaker failure timer with AXI4-Lite registers, events, tallies and record ring.
// Assumes all inputs synchronous to CLK_SYS_IN; CYCLE_TICK_IN pulses once a program cycle.
//
// Notes on behaviour
// - Current mode: pick-up runs timer, trip ignored.
// - Current mode: timer clears when current drops.
// - And mode: counting waits for trip contact.
// - And mode: output on expiry with conditions.
// - And mode: reset when current or trip drops.
// - Or mode: current or trip starts counting.
// - Or mode: output after delay of either.
// - Or mode: reset only when both drop.
// - Input mode: digital input runs the timer.
// - Maskable ON/OFF time-stamped events per signal.
// - Clearable tallies: start, retrip, failure, blocked.
// - Ring of twelve records, captured on ON.
// - Record holds time, event, currents, remaining, group.
// - Retrip and failure outputs driven at ports.
// - Block at pick-up gives blocked, timer released.
// - Retrip after retrip delay when enabled.
// - One pick-up drives both timers; default delays.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bft_timer
    import bft_pkg::*;
#(
    parameter int CNT_W = 16
)(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    // Protection inputs
    input wire logic CYCLE_TICK_IN,
    input wire logic PHASE_PICKUP_IN,
    input wire logic RES_PICKUP_IN,
    input wire logic TRIP_MON_IN,
    input wire logic DIG_IN,
    input wire logic BLOCK_IN,
    input wire logic [31:0] TIME_IN,
    input wire logic [15:0] PHASE_CUR_IN,
    input wire logic [15:0] RES_CUR_IN,
    input wire logic [2:0] SET_GROUP_IN,
    // Protection outputs
    output logic RETRIP_OUT,
    output logic BREAKER_FAILURE_OUT,
    output logic EVENT_VALID_OUT,
    output logic [3:0] EVENT_CODE_OUT,
    output logic [31:0] EVENT_STAMP_OUT,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] crit;
        logic ret_en;
        logic [7:0] on_mask;
        logic [7:0] off_mask;
        logic [CNT_W-1:0] ret_dly;
        logic [CNT_W-1:0] cbf_dly;
        logic [CNT_W-1:0] cnt;
        logic [3:0][15:0] tally;
        logic [7:0] lvl;
        logic [7:0] seen;
        bft_status_type status;
        logic retrip;
        logic cbf;
        logic ev_v;
        logic [3:0] ev_code;
        logic [31:0] ev_stamp;
        bft_rec_type [REC_DEPTH-1:0] recs;
        logic [3:0] wp;
        logic [3:0] nrec;
        logic [3:0] sel;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bft_state_type;

    bft_state_type r_reg;
    bft_state_type r_next;
    logic cur;
    logic act;
    logic eff;
    logic blk;
    logic [7:0] lvl_new;
    logic [3:0] clr;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int b = 0; b < 4; b++)
        begin
            if (s[b])
            begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [15:0] remain(input logic [CNT_W-1:0] d,
                                           input logic [CNT_W-1:0] c);
        return (c < d) ? 16'(d - c) : 16'h0000;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic found;
        logic [31:0] ctrl;
        logic [31:0] rd;
        bft_rec_type rc;
        r_next = r_reg;
        found = 1'b0;
        ctrl = '0;
        rd = '0;
        rc = '0;
        cur = PHASE_PICKUP_IN | RES_PICKUP_IN;
        unique case (r_reg.crit)
            CRIT_CUR: act = cur;
            CRIT_AND: act = cur & TRIP_MON_IN;
            CRIT_OR: act = cur | TRIP_MON_IN;
            CRIT_DIG: act = DIG_IN;
        endcase
        eff = act & ~BLOCK_IN;
        blk = act & BLOCK_IN;
        if (!eff)
        begin
            r_next.cnt = '0;
        end
        else if (CYCLE_TICK_IN && r_reg.cnt != '1)
        begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
        r_next.retrip = r_reg.ret_en & eff & (r_next.cnt >= r_reg.ret_dly);
        r_next.cbf = eff & (r_next.cnt >= r_reg.cbf_dly);
        if (blk)
            r_next.status = ST_BLOCKED;
        else if (r_next.cbf)
            r_next.status = ST_CBF;
        else if (r_next.retrip)
            r_next.status = ST_RETRIP;
        else if (eff)
            r_next.status = ST_START;
        else
            r_next.status = ST_NORMAL;
        lvl_new = {RES_PICKUP_IN, PHASE_PICKUP_IN, DIG_IN, TRIP_MON_IN,
                   blk, r_next.cbf, r_next.retrip, eff};
        r_next.lvl = lvl_new;
        // Register bus write.
        clr = '0;
        if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid)
        begin
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OK;
            r_next.aw_got = 1'b0;
            r_next.w_got = 1'b0;
            unique case ({r_reg.waddr[7:2], 2'b00})
                OFF_CTRL:
                begin
                    ctrl = {8'h00, r_reg.off_mask, r_reg.on_mask, 5'h00, r_reg.ret_en, r_reg.crit};
                    ctrl = merge(ctrl, r_reg.wdata, r_reg.wstrb);
                    r_next.crit = ctrl[1:0];
                    r_next.ret_en = ctrl[CTRL_RET_EN_BIT];
                    r_next.on_mask = ctrl[CTRL_ON_LSB +: 8];
                    r_next.off_mask = ctrl[CTRL_OFF_LSB +: 8];
                end
                OFF_RET_DLY: r_next.ret_dly = CNT_W'(merge(32'(r_reg.ret_dly), r_reg.wdata, r_reg.wstrb));
                OFF_CBF_DLY: r_next.cbf_dly = CNT_W'(merge(32'(r_reg.cbf_dly), r_reg.wdata, r_reg.wstrb));
                OFF_CNT_CLR: clr = r_reg.wstrb[0] ? r_reg.wdata[3:0] : 4'h0;
                OFF_REC_SEL: r_next.sel = r_reg.wstrb[0] ? r_reg.wdata[3:0] : r_reg.sel;
                OFF_STATUS, OFF_CNT0, OFF_CNT1, OFF_CNT2, OFF_CNT3, OFF_REC_TIME,
                OFF_REC_CUR, OFF_REC_REM, OFF_REC_EVT: r_next.bresp = RESP_OK;
                default: r_next.bresp = RESP_ERR;
            endcase
        end
        if (r_reg.bvalid && BREADY_IN)
            r_next.bvalid = 1'b0;
        if (AWVALID_IN && r_reg.awready)
        begin
            r_next.aw_got = 1'b1;
            r_next.waddr = AWADDR_IN;
        end
        if (WVALID_IN && r_reg.wready)
        begin
            r_next.w_got = 1'b1;
            r_next.wdata = WDATA_IN;
            r_next.wstrb = WSTRB_IN;
        end
        // Tallies: a rising edge and a clear in the same cycle leave the tally at one.
        for (int i = 0; i < 4; i++)
        begin
            if (lvl_new[i] && !r_reg.lvl[i])
                r_next.tally[i] = clr[i] ? 16'h0001 : r_reg.tally[i] + 16'h0001;
            else if (clr[i])
                r_next.tally[i] = 16'h0000;
        end
        // Events: one change reported per cycle, lowest signal first.
        r_next.ev_v = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (!found && r_reg.seen[i] != r_reg.lvl[i])
            begin
                found = 1'b1;
                r_next.seen[i] = r_reg.lvl[i];
                r_next.ev_v = r_reg.lvl[i] ? r_reg.on_mask[i] : r_reg.off_mask[i];
                r_next.ev_code = {3'(i), r_reg.lvl[i]};
                r_next.ev_stamp = TIME_IN;
                if (r_reg.lvl[i])
                begin
                    r_next.recs[r_reg.wp] = '{TIME_IN, {3'(i), 1'b1}, PHASE_CUR_IN, RES_CUR_IN,
                                             remain(r_reg.ret_dly, r_reg.cnt),
                                             remain(r_reg.cbf_dly, r_reg.cnt),
                                             SET_GROUP_IN};
                    r_next.wp = (r_reg.wp == 4'(REC_DEPTH - 1)) ? 4'h0 : r_reg.wp + 4'h1;
                    r_next.nrec = (r_reg.nrec == 4'(REC_DEPTH)) ? r_reg.nrec : r_reg.nrec + 4'h1;
                end
            end
        end
        // Register bus read.
        if (r_reg.sel < 4'(REC_DEPTH))
            rc = r_reg.recs[r_reg.sel];
        if (r_reg.rvalid && RREADY_IN)
            r_next.rvalid = 1'b0;
        if (ARVALID_IN && r_reg.arready)
        begin
            r_next.rvalid = 1'b1;
            r_next.rresp = RESP_OK;
            unique case ({ARADDR_IN[7:2], 2'b00})
                OFF_CTRL: rd = {8'h00, r_reg.off_mask, r_reg.on_mask, 5'h00, r_reg.ret_en, r_reg.crit};
                OFF_RET_DLY: rd = 32'(r_reg.ret_dly);
                OFF_CBF_DLY: rd = 32'(r_reg.cbf_dly);
                OFF_STATUS: rd = {24'h0, r_reg.cbf, r_reg.retrip, 1'b0, r_reg.status};
                OFF_CNT_CLR: rd = 32'h0000_0000;
                OFF_CNT0: rd = {16'h0, r_reg.tally[0]};
                OFF_CNT1: rd = {16'h0, r_reg.tally[1]};
                OFF_CNT2: rd = {16'h0, r_reg.tally[2]};
                OFF_CNT3: rd = {16'h0, r_reg.tally[3]};
                OFF_REC_SEL: rd = {16'h0, r_reg.nrec, r_reg.wp, 4'h0, r_reg.sel};
                OFF_REC_TIME: rd = rc.stamp;
                OFF_REC_CUR: rd = {rc.ph, rc.res};
                OFF_REC_REM: rd = {rc.t_ret, rc.t_cbf};
                OFF_REC_EVT: rd = {21'h0, rc.grp, 4'h0, rc.code};
                default: r_next.rresp = RESP_ERR;
            endcase
            r_next.rdata = rd;
        end
        r_next.awready = ~r_next.aw_got & ~r_next.bvalid;
        r_next.wready = ~r_next.w_got & ~r_next.bvalid;
        r_next.arready = ~r_next.rvalid;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            r_reg <= '0;
            r_reg.crit <= CRIT_CUR;
            r_reg.ret_en <= 1'b1;
            r_reg.on_mask <= MASK_RST;
            r_reg.off_mask <= MASK_RST;
            r_reg.ret_dly <= CNT_W'(RET_TICKS);
            r_reg.cbf_dly <= CNT_W'(CBF_TICKS);
            r_reg.status <= ST_NORMAL;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign RETRIP_OUT = r_reg.retrip;
    assign BREAKER_FAILURE_OUT = r_reg.cbf;
    assign EVENT_VALID_OUT = r_reg.ev_v;
    assign EVENT_CODE_OUT = r_reg.ev_code;
    assign EVENT_STAMP_OUT = r_reg.ev_stamp;
    assign AWREADY_OUT = r_reg.awready;
    assign WREADY_OUT = r_reg.wready;
    assign BVALID_OUT = r_reg.bvalid;
    assign BRESP_OUT = r_reg.bresp;
    assign ARREADY_OUT = r_reg.arready;
    assign RVALID_OUT = r_reg.rvalid;
    assign RDATA_OUT = r_reg.rdata;
    assign RRESP_OUT = r_reg.rresp;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    cur_counts_a: assert property (r_reg.crit == CRIT_CUR && cur && !BLOCK_IN && CYCLE_TICK_IN
        && r_reg.cnt < 16'h00FF |=> r_reg.cnt == $past(r_reg.cnt) + 1'b1)
        else $error("current mode timer did not advance");
    cur_clear_a: assert property (r_reg.crit == CRIT_CUR && !cur |=> r_reg.cnt == 0 ##1 !r_reg.cbf
        || r_reg.cnt != 0)
        else $error("current mode timer not cleared");
    and_reset_a: assert property (r_reg.crit == CRIT_AND && !(cur && TRIP_MON_IN)
        |=> r_reg.cnt == 0 && !BREAKER_FAILURE_OUT)
        else $error("and mode timer not reset");
    or_hold_a: assert property (r_reg.crit == CRIT_OR && (cur || TRIP_MON_IN) && !BLOCK_IN
        |=> r_reg.cnt >= $past(r_reg.cnt))
        else $error("or mode timer dropped while a condition held");
    dig_run_a: assert property (r_reg.crit == CRIT_DIG && !DIG_IN |=> r_reg.cnt == 0)
        else $error("input mode timer ran without input");
    block_hold_a: assert property (act && BLOCK_IN |=> r_reg.status == ST_BLOCKED
        && !BREAKER_FAILURE_OUT && !RETRIP_OUT)
        else $error("blocked pick-up still processed");
    cbf_expiry_a: assert property (BREAKER_FAILURE_OUT |-> r_reg.cnt >= r_reg.cbf_dly
        && r_reg.status == ST_CBF)
        else $error("failure output before delay");
    retrip_delay_a: assert property (RETRIP_OUT |-> r_reg.ret_en
        && r_reg.cnt >= r_reg.ret_dly)
        else $error("retrip output without delay or enable");
    tally_step_a: assert property (lvl_new[0] && !r_reg.lvl[0] && !clr[0]
        |=> r_reg.tally[0] == $past(r_reg.tally[0]) + 16'h0001)
        else $error("start tally missed");
    ring_bound_a: assert property (r_reg.wp < 4'(REC_DEPTH) && r_reg.nrec <= 4'(REC_DEPTH))
        else $error("record ring out of range");

    cbf_fire_c: cover property (r_reg.crit == CRIT_OR && BREAKER_FAILURE_OUT);
    retrip_fire_c: cover property (r_reg.crit == CRIT_AND && RETRIP_OUT ##1 BREAKER_FAILURE_OUT);
    blocked_c: cover property (r_reg.status == ST_BLOCKED);
    ring_full_c: cover property (r_reg.nrec == 4'(REC_DEPTH));
endmodule
`default_nettype wire

// file: test/bft_trip_model.sv
// Model of the primary trip contact and of the upstream breaker.
// Assumes one clock shared with the design and an active high reset.
`timescale 1ns/1ps
`default_nettype none
module bft_trip_model
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Primary trip contact
    input wire logic trip_cmd_in,
    input wire logic [3:0] lag_in,
    output logic trip_mon_out,
    // Upstream breaker
    input wire logic fail_in,
    output logic [7:0] trips_out
);
    logic [3:0] held_reg;
    logic fail_reg;
    // The contact closes lag_in cycles after the command and opens at once.
    assign trip_mon_out = trip_cmd_in && (held_reg >= lag_in);
    // The upstream breaker trips once on each rising failure command.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            held_reg <= 4'h0;
            fail_reg <= 1'b0;
            trips_out <= 8'h00;
        end
        else
        begin
            held_reg <= (!trip_cmd_in) ? 4'h0 : (held_reg == 4'hF) ? held_reg : held_reg + 4'h1;
            fail_reg <= fail_in;
            trips_out <= trips_out + {7'h00, fail_in && !fail_reg};
        end
    end
endmodule
`default_nettype wire

// file: test/bft_timer_tb.sv
// Self-checking bench for the breaker failure timer.
// Assumes the trip contact model and a program tick on every clock, except during the no-tick step of t_dig.
`timescale 1ns/1ps
`default_nettype none
module bft_timer_tb
    import bft_pkg::*;
;
    localparam logic [31:0] RD = 32'h2;
    localparam logic [31:0] FD = 32'h5;
    logic clk, rst, tick, ph, res, trip_cmd, trip_mon, dig, blk, ret, bf, ev_v;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, trips;
    logic [31:0] wdata, rdata, rv, tm, ev_t;
    logic [3:0] ev_c, lag;
    logic [1:0] bresp, rresp, rr;
    logic [3:0] evq[$];
    int n_errors, checked;
    int bad_stamp;
    bft_timer u_bft_timer (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CYCLE_TICK_IN(tick), .PHASE_PICKUP_IN(ph),
        .RES_PICKUP_IN(res), .TRIP_MON_IN(trip_mon), .DIG_IN(dig), .BLOCK_IN(blk),
        .TIME_IN(tm), .PHASE_CUR_IN(16'h1234), .RES_CUR_IN(16'h0056), .SET_GROUP_IN(3'h5),
        .RETRIP_OUT(ret), .BREAKER_FAILURE_OUT(bf), .EVENT_VALID_OUT(ev_v),
        .EVENT_CODE_OUT(ev_c), .EVENT_STAMP_OUT(ev_t), .AWADDR_IN(awaddr),
        .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(4'hF),
        .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready)
    );
    bft_trip_model u_bft_trip_model (.clk_in(clk), .rst_in(rst), .trip_cmd_in(trip_cmd),
        .lag_in(lag), .trip_mon_out(trip_mon), .fail_in(bf), .trips_out(trips));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) tm <= tm + 32'h1;
    always @(posedge clk)
    begin
        if (ev_v === 1'b1)
        begin
            evq.push_back(ev_c);
            if (ev_t !== tm - 32'h1)
                bad_stamp++;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        rr = bresp;
        bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    task ctl(input logic [1:0] c, input logic [7:0] on, input logic [7:0] off);
        axw(OFF_CTRL, {8'h00, off, on, 6'h01, c});
    endtask
    task fire(input logic [31:0] d);
        wt(d - 1);
        chk("failure early", bf, 1'b0);
        wt(1);
        chk("failure late", bf, 1'b1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        axr(OFF_CTRL);
        chk("ctrl reset", rv, 32'h00FFFF04);
        axr(OFF_RET_DLY);
        chk("retrip delay reset", rv, RET_TICKS);
        axr(OFF_CBF_DLY);
        chk("failure delay reset", rv, CBF_TICKS);
        axw(OFF_STATUS, 32'hFF);
        chk("read-only write resp", rr, RESP_OK);
        axr(OFF_STATUS);
        chk("status idle", rv, 32'h1);
        axr(8'h3C);
        chk("unmapped resp", rr, RESP_ERR);
        axw(OFF_RET_DLY, RD);
        axw(OFF_CBF_DLY, FD);
        $display("test regs done");
    endtask
    task t_cur;
        ctl(CRIT_CUR, 8'hFF, 8'hFF);
        @(posedge clk);
        trip_cmd <= 1'b1;
        wt(FD + 3);
        chk("trip ignored", bf, 1'b0);
        @(posedge clk);
        ph <= 1'b1;
        wt(RD - 1);
        chk("retrip early", ret, 1'b0);
        wt(1);
        chk("retrip late", ret, 1'b1);
        fire(FD - RD);
        axr(OFF_STATUS);
        chk("status failure", rv, 32'hC8);
        @(posedge clk);
        ph <= 1'b0;
        trip_cmd <= 1'b0;
        wt(1);
        chk("failure cleared", bf, 1'b0);
        @(posedge clk);
        res <= 1'b1;
        fire(FD);
        @(posedge clk);
        res <= 1'b0;
        $display("test current done");
    endtask
    task t_and;
        ctl(CRIT_AND, 8'hFF, 8'hFF);
        @(posedge clk);
        ph <= 1'b1;
        wt(FD + 3);
        chk("frozen", bf, 1'b0);
        @(posedge clk);
        trip_cmd <= 1'b1;
        fire(FD);
        @(posedge clk);
        trip_cmd <= 1'b0;
        wt(1);
        chk("trip drop", bf, 1'b0);
        @(posedge clk);
        trip_cmd <= 1'b1;
        fire(FD);
        @(posedge clk);
        ph <= 1'b0;
        wt(1);
        chk("current drop", bf, 1'b0);
        @(posedge clk);
        trip_cmd <= 1'b0;
        $display("test and done");
    endtask
    task t_or;
        ctl(CRIT_OR, 8'hFF, 8'hFF);
        @(posedge clk);
        lag <= 4'h3;
        trip_cmd <= 1'b1;
        fire(FD + 3);
        @(posedge clk);
        ph <= 1'b1;
        trip_cmd <= 1'b0;
        wt(3);
        chk("either holds", bf, 1'b1);
        @(posedge clk);
        ph <= 1'b0;
        wt(1);
        chk("both dropped", bf, 1'b0);
        @(posedge clk);
        ph <= 1'b1;
        lag <= 4'h0;
        fire(FD);
        @(posedge clk);
        ph <= 1'b0;
        $display("test or done");
    endtask
    task t_dig;
        ctl(CRIT_DIG, 8'hFF, 8'hFF);
        @(posedge clk);
        dig <= 1'b1;
        tick <= 1'b0;
        wt(FD + 3);
        chk("no tick", bf, 1'b0);
        @(posedge clk);
        tick <= 1'b1;
        fire(FD);
        @(posedge clk);
        dig <= 1'b0;
        wt(1);
        chk("input release", bf, 1'b0);
        $display("test input done");
    endtask
    task t_blk;
        logic [31:0] e [4];
        e = '{32'h2, 32'h1, 32'h1, 32'h2};
        axw(OFF_CNT_CLR, 32'hF);
        axr(OFF_CNT0);
        chk("tally cleared", rv, 32'h0);
        ctl(CRIT_CUR, 8'hFF, 8'hFF);
        @(posedge clk);
        ph <= 1'b1;
        fire(FD);
        @(posedge clk);
        ph <= 1'b0;
        @(posedge clk);
        blk <= 1'b1;
        @(posedge clk);
        ph <= 1'b1;
        wt(FD + 3);
        chk("blocked output", bf, 1'b0);
        axr(OFF_STATUS);
        chk("status blocked", rv, 32'h10);
        @(posedge clk);
        ph <= 1'b0;
        @(posedge clk);
        blk <= 1'b0;
        @(posedge clk);
        ph <= 1'b1;
        @(posedge clk);
        blk <= 1'b1;
        wt(FD + 3);
        chk("start released", bf, 1'b0);
        @(posedge clk);
        ph <= 1'b0;
        @(posedge clk);
        blk <= 1'b0;
        wt(2);
        for (int i = 0; i < 4; i++)
        begin
            axr(OFF_CNT0 + 8'(4 * i));
            chk("tally", rv, e[i]);
        end
        axw(OFF_CNT_CLR, 32'h2);
        axr(OFF_CNT0 + 8'h4);
        chk("retrip tally clear", rv, 32'h0);
        axr(OFF_CNT0 + 8'h8);
        chk("failure tally kept", rv, 32'h1);
        $display("test block done");
    endtask
    task t_evt;
        int on_n, hit;
        ctl(CRIT_CUR, 8'hFF, 8'h00);
        wt(8);
        evq.delete();
        @(posedge clk);
        ph <= 1'b1;
        wt(2);
        @(posedge clk);
        ph <= 1'b0;
        wt(8);
        on_n = 0;
        hit = 0;
        foreach (evq[i])
        begin
            on_n += evq[i][0];
            hit += (evq[i] === 4'hD);
        end
        chk("off events masked", evq.size(), on_n);
        chk("phase on event", hit, 1);
        chk("event stamp", bad_stamp, 0);
        $display("test events done");
    endtask
    task t_rec;
        logic [3:0] s;
        axr(OFF_REC_SEL);
        chk("record count", rv[15:12], 4'hC);
        s = (rv[11:8] == 4'h0) ? 4'hB : rv[11:8] - 4'h1;
        axw(OFF_REC_SEL, {28'h0, s});
        axr(OFF_REC_CUR);
        chk("record currents", rv, 32'h12340056);
        axr(OFF_REC_EVT);
        chk("record group", rv[10:8], 3'h5);
        axw(OFF_REC_SEL, 32'hC);
        axr(OFF_REC_TIME);
        chk("empty slot", rv, 32'h0);
        chk("upstream trips", trips, 8'h08);
        $display("test records done");
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("watchdog expired");
        final_report;
    end
    initial
    begin
        {rst, tick} = 2'b11;
        {ph, res, trip_cmd, dig, blk, awvalid, wvalid, bready, arvalid, rready} = 10'h0;
        {awaddr, araddr, wdata, tm, lag} = 84'h0;
        n_errors = 0;
        checked = 0;
        bad_stamp = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs;
        t_cur;
        t_and;
        t_or;
        t_dig;
        t_blk;
        t_evt;
        t_rec;
        final_report;
    end
endmodule
`default_nettype wire
